// [rtl/bafc_map.svh]
`ifndef BAFC_MAP_SVH
`define BAFC_MAP_SVH
`define BAFC_NUM_PORTS 10
`define BAFC_CNT_W 12
`define BAFC_CLASS_MIN 3'h2
`define BAFC_PCT_SCALE 8'h64
`define BAFC_OFF_CTRL 8'h00
`define BAFC_OFF_PORT_RES 8'h04
`define BAFC_OFF_XOFF_THR 8'h08
`define BAFC_OFF_SHARED 8'h0C
`define BAFC_OFF_CLASS0 8'h10
`define BAFC_OFF_CLASS1 8'h14
`define BAFC_OFF_CLASS2 8'h18
`define BAFC_OFF_LOW_THR 8'h1C
`define BAFC_OFF_DROP_PCT 8'h20
`define BAFC_OFF_MC_THR 8'h24
`define BAFC_OFF_PRIO_MAP 8'h28
`define BAFC_OFF_PAUSE_TIME 8'h2C
`define BAFC_OFF_STATUS 8'h30
`define BAFC_OFF_SHARED_USED 8'h34
`define BAFC_OFF_MC_COUNT 8'h38
`define BAFC_OFF_DROP_COUNT 8'h3C
`define BAFC_CTRL_FC_EN_BIT 16
`define BAFC_CTRL_FORCE_BE_BIT 17
`define BAFC_RST_PORT_RES 12'h010
`define BAFC_RST_XOFF_THR 12'h008
`define BAFC_RST_SHARED 12'h100
`define BAFC_RST_CLASS 12'h020
`define BAFC_RST_LOW_THR 12'h004
`define BAFC_RST_DROP_PCT 7'h32
`define BAFC_RST_MC_THR 12'h040
`define BAFC_RST_PRIO_MAP 16'hFA50
`define BAFC_RST_PAUSE_TIME 16'hFFFF
`define BAFC_LFSR_SEED 8'hA5
`endif

// [rtl/bafc_pkg.sv]
`include "bafc_map.svh"
package bafc_pkg;
  typedef logic [`BAFC_CNT_W-1:0] bafc_cnt_t;
  typedef logic [3:0] bafc_port_t;
  typedef logic [`BAFC_NUM_PORTS-1:0] bafc_pmask_t;
  typedef enum logic [1:0] {BAFC_Q_LOWEST, BAFC_Q_THIRD, BAFC_Q_SECOND, BAFC_Q_TOP} bafc_queue_e;
  typedef enum logic [1:0] {BAFC_DS_BE, BAFC_DS_AF1, BAFC_DS_AF0, BAFC_DS_NM_EF} bafc_ds_e;
  typedef enum logic [1:0] {BAFC_RG_CLASS, BAFC_RG_SHARED, BAFC_RG_PORT, BAFC_RG_NONE} bafc_region_e;
  typedef struct packed {
    bafc_port_t src;
    logic [2:0] prio;
    logic mcast;
    logic congest;
    logic wred_drop;
  } bafc_adm_req_s;
  typedef struct packed {
    logic drop;
    bafc_region_e region;
    logic [1:0] section;
    bafc_queue_e queue;
    bafc_ds_e ds;
    bafc_port_t src;
  } bafc_adm_dec_s;
  typedef struct packed {
    bafc_port_t src;
    bafc_region_e region;
    logic [1:0] section;
    logic mcast;
  } bafc_rel_s;
  typedef struct packed {
    bafc_port_t port;
    logic [15:0] time_q;
  } bafc_pause_s;
  typedef struct packed {
    bafc_pmask_t fc_cap;
    logic fc_en;
    logic force_be;
    bafc_cnt_t port_res;
    bafc_cnt_t xoff_thr;
    bafc_cnt_t shared_size;
    logic [2:0][`BAFC_CNT_W-1:0] class_res;
    bafc_cnt_t low_thr;
    logic [6:0] drop_pct;
    bafc_cnt_t mc_thr;
    logic [15:0] prio_map;
    logic [15:0] pause_time;
  } bafc_cfg_s;
  typedef struct packed {
    bafc_pmask_t pause_state;
    logic mc_xoff;
    bafc_cnt_t shared_used;
    bafc_cnt_t mc_count;
    logic [15:0] drop_count;
  } bafc_stat_s;
endpackage

// [rtl/bafc_apb.sv]
`timescale 1ns/1ps
module bafc_apb import bafc_pkg::*; (
  // System
  input wire logic clk,
  input wire logic reset,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Block side
  output bafc_cfg_s cfg,
  input wire bafc_stat_s stat
);
  bafc_cfg_s cfg_r, cfg_nxt;
  logic [31:0] rd;
  logic hit;

  // Shared by read mux and error flag
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= `BAFC_OFF_DROP_COUNT);
  endfunction

  assign pready = 1'b1;
  assign hit = mapped(paddr);
  assign pslverr = psel && penable && !hit;
  assign cfg = cfg_r;

  always_comb begin
    rd = 32'h0;
    case (paddr)
      `BAFC_OFF_CTRL: rd = {14'h0, cfg_r.force_be, cfg_r.fc_en, 6'h0, cfg_r.fc_cap};
      `BAFC_OFF_PORT_RES: rd = {20'h0, cfg_r.port_res};
      `BAFC_OFF_XOFF_THR: rd = {20'h0, cfg_r.xoff_thr};
      `BAFC_OFF_SHARED: rd = {20'h0, cfg_r.shared_size};
      `BAFC_OFF_CLASS0: rd = {20'h0, cfg_r.class_res[0]};
      `BAFC_OFF_CLASS1: rd = {20'h0, cfg_r.class_res[1]};
      `BAFC_OFF_CLASS2: rd = {20'h0, cfg_r.class_res[2]};
      `BAFC_OFF_LOW_THR: rd = {20'h0, cfg_r.low_thr};
      `BAFC_OFF_DROP_PCT: rd = {25'h0, cfg_r.drop_pct};
      `BAFC_OFF_MC_THR: rd = {20'h0, cfg_r.mc_thr};
      `BAFC_OFF_PRIO_MAP: rd = {16'h0, cfg_r.prio_map};
      `BAFC_OFF_PAUSE_TIME: rd = {16'h0, cfg_r.pause_time};
      `BAFC_OFF_STATUS: rd = {15'h0, stat.mc_xoff, 6'h0, stat.pause_state};
      `BAFC_OFF_SHARED_USED: rd = {20'h0, stat.shared_used};
      `BAFC_OFF_MC_COUNT: rd = {20'h0, stat.mc_count};
      `BAFC_OFF_DROP_COUNT: rd = {16'h0, stat.drop_count};
      default: rd = 32'h0;
    endcase
  end
  assign prdata = hit ? rd : 32'h0;

  always_comb begin
    cfg_nxt = cfg_r;
    if (psel && penable && pwrite) begin
      case (paddr)
        `BAFC_OFF_CTRL: begin
          cfg_nxt.fc_cap = pwdata[`BAFC_NUM_PORTS-1:0];
          cfg_nxt.fc_en = pwdata[`BAFC_CTRL_FC_EN_BIT];
          cfg_nxt.force_be = pwdata[`BAFC_CTRL_FORCE_BE_BIT];
        end
        `BAFC_OFF_PORT_RES: cfg_nxt.port_res = pwdata[11:0];
        `BAFC_OFF_XOFF_THR: cfg_nxt.xoff_thr = pwdata[11:0];
        `BAFC_OFF_SHARED: cfg_nxt.shared_size = pwdata[11:0];
        `BAFC_OFF_CLASS0: cfg_nxt.class_res[0] = pwdata[11:0];
        `BAFC_OFF_CLASS1: cfg_nxt.class_res[1] = pwdata[11:0];
        `BAFC_OFF_CLASS2: cfg_nxt.class_res[2] = pwdata[11:0];
        `BAFC_OFF_LOW_THR: cfg_nxt.low_thr = pwdata[11:0];
        `BAFC_OFF_DROP_PCT: cfg_nxt.drop_pct = pwdata[6:0];
        `BAFC_OFF_MC_THR: cfg_nxt.mc_thr = pwdata[11:0];
        `BAFC_OFF_PRIO_MAP: cfg_nxt.prio_map = pwdata[15:0];
        `BAFC_OFF_PAUSE_TIME: cfg_nxt.pause_time = pwdata[15:0];
        default: cfg_nxt = cfg_r;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_r.fc_cap <= '0;
      cfg_r.fc_en <= 1'b0;
      cfg_r.force_be <= 1'b0;
      cfg_r.port_res <= `BAFC_RST_PORT_RES;
      cfg_r.xoff_thr <= `BAFC_RST_XOFF_THR;
      cfg_r.shared_size <= `BAFC_RST_SHARED;
      cfg_r.class_res <= {3{`BAFC_RST_CLASS}};
      cfg_r.low_thr <= `BAFC_RST_LOW_THR;
      cfg_r.drop_pct <= `BAFC_RST_DROP_PCT;
      cfg_r.mc_thr <= `BAFC_RST_MC_THR;
      cfg_r.prio_map <= `BAFC_RST_PRIO_MAP;
      cfg_r.pause_time <= `BAFC_RST_PAUSE_TIME;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end
endmodule

// [rtl/bafc_pause.sv]
`timescale 1ns/1ps
module bafc_pause import bafc_pkg::*; (
  // System
  input wire logic clk,
  input wire logic reset,
  // Hold-off levels and pause time
  input wire bafc_pmask_t state,
  input wire logic [15:0] pause_time,
  // Pause frame request to MAC
  output logic frm_valid,
  input wire logic frm_ready,
  output bafc_pause_s frm
);
  typedef enum logic {PS_IDLE, PS_SEND} bafc_ps_e;
  bafc_ps_e st_r, st_nxt;
  bafc_pmask_t prev_r, prev_nxt, pend_r, pend_nxt;
  bafc_pause_s frm_r, frm_nxt;
  logic found;

  assign frm_valid = (st_r == PS_SEND);
  assign frm = frm_r;

  always_comb begin
    st_nxt = st_r;
    frm_nxt = frm_r;
    prev_nxt = state;
    pend_nxt = pend_r;
    found = 1'b0;
    // A send completing in the same cycle as a new change stays pending
    if (st_r == PS_SEND && frm_ready) begin
      pend_nxt[frm_r.port] = 1'b0;
    end
    pend_nxt = pend_nxt | (state ^ prev_r);
    case (st_r)
      PS_IDLE: begin
        for (int i = 0; i < `BAFC_NUM_PORTS; i++) begin
          if (pend_r[i] && !found) begin
            found = 1'b1;
            frm_nxt.port = 4'(i);
            frm_nxt.time_q = state[i] ? pause_time : 16'h0000; // RL19
          end
        end
        if (found) begin
          st_nxt = PS_SEND;
        end
      end
      PS_SEND: begin
        if (frm_ready) begin
          st_nxt = PS_IDLE;
        end
      end
      default: st_nxt = PS_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= PS_IDLE;
      prev_r <= '0;
      pend_r <= '0;
      frm_r <= '0;
    end else begin
      st_r <= st_nxt;
      prev_r <= prev_nxt;
      pend_r <= pend_nxt;
      frm_r <= frm_nxt;
    end
  end
endmodule

// [rtl/bafc_top.sv]
// Behaviour
// [RL1] Best-effort frame dropped when its source port has no buffer left.
// [RL2] Congested queue and empty shared pool drop the frame at programmed percentage.
// [RL3] Congested queue and source reservation below low threshold drop the frame.
// [RL4] All scarcity drops disabled for flow-control capable source ports; the code still drops their frames when no region has room.
// [RL5] Flow control on: source reservation shortage pauses that port's partner.
// [RL6] Non best-effort frames still obey WRED even on flow-control ports.
// [RL7] Programmable priority map can steer flow-control port traffic to best effort.
// [RL8] Unicast pause asserted once programmed count of reserved slots is used.
// [RL9] Unicast pause released only when all reserved slots of port are free.
// [RL10] Single frame to congested output never pauses its source.
// [RL11] Multicast pause asserted when global multicast count exceeds threshold.
// [RL12] Multicast pause released when global multicast count falls below threshold.
// [RL13] Top queue NM+EF, next two AF0/AF1, lowest queue best effort.
// [RL14] Traffic from flow-control enabled ports classified as best effort.
// [RL15] Best-effort queue served only while all higher queues are idle.
// [RL16] Class reservations for NM/EF and AF; random discard on AF and BE; the code also drops NM/EF frames on WRED.
// [RL17] Allocate class section first, then shared pool, then source reservation.
// [RL18] Frame held in temporary region until class known, then judged; the code has no temporary region and judges each request on arrival.
// [RL19] Hold-off sent as pause frames: nonzero time asserts, zero releases.
// [RL20] Link partner stops sending new frames until release arrives.
`timescale 1ns/1ps
module bafc_top import bafc_pkg::*; (
  // System
  input wire logic CLK,
  input wire logic RESET,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Admission request and decision
  input wire logic ADM_VALID,
  input wire bafc_adm_req_s ADM_REQ,
  output logic DEC_VALID,
  output bafc_adm_dec_s DEC,
  // Buffer release
  input wire logic REL_VALID,
  input wire bafc_rel_s REL,
  // Hold-off toward link partners
  output bafc_pmask_t PAUSE_STATE,
  output logic PAUSE_VALID,
  input wire logic PAUSE_READY,
  output bafc_pause_s PAUSE_FRM,
  // Uplink queue service
  input wire logic [3:0] QUEUE_BUSY,
  output logic [3:0] QUEUE_GRANT
);
  bafc_cfg_s cfg;
  bafc_stat_s stat;

  bafc_cnt_t port_used_r [`BAFC_NUM_PORTS];
  bafc_cnt_t port_used_nxt [`BAFC_NUM_PORTS];
  bafc_cnt_t class_used_r [3];
  bafc_cnt_t class_used_nxt [3];
  bafc_cnt_t shared_used_r, shared_used_nxt;
  bafc_cnt_t mc_count_r, mc_count_nxt;
  logic [15:0] drop_count_r, drop_count_nxt;
  logic [7:0] lfsr_r, lfsr_nxt;
  logic dec_valid_r, dec_valid_nxt;
  bafc_adm_dec_s dec_r, dec_nxt;
  bafc_pmask_t uc_xoff_r, uc_xoff_nxt;
  logic mc_xoff_r, mc_xoff_nxt;

  logic [1:0] sec;
  bafc_queue_e q;
  logic fc, class_ok, shared_ok, port_ok, no_room, chance, drop;
  bafc_cnt_t res_left;
  logic [14:0] scaled;
  bafc_pmask_t fc_mask;

  function automatic bafc_ds_e ds_of(input bafc_queue_e qq);
    case (qq)
      BAFC_Q_TOP: ds_of = BAFC_DS_NM_EF;
      BAFC_Q_SECOND: ds_of = BAFC_DS_AF0;
      BAFC_Q_THIRD: ds_of = BAFC_DS_AF1;
      default: ds_of = BAFC_DS_BE;
    endcase
  endfunction

  // Clamped so a stray release or a long burst never wraps a count
  function automatic bafc_cnt_t cnt_inc(input bafc_cnt_t v);
    cnt_inc = (v == 12'hFFF) ? v : v + 12'h001;
  endfunction

  function automatic bafc_cnt_t cnt_dec(input bafc_cnt_t v);
    cnt_dec = (v == 12'h000) ? v : v - 12'h001;
  endfunction

  // Priorities 1 and 0 have no class section; index kept inside the array
  function automatic logic [1:0] sec_of(input logic [2:0] pr);
    sec_of = (pr >= `BAFC_CLASS_MIN) ? 2'(pr[2:1] - 2'h1) : 2'h0;
  endfunction

  bafc_apb u_apb (
    .clk(CLK),
    .reset(RESET),
    .psel(PSEL),
    .penable(PENABLE),
    .pwrite(PWRITE),
    .paddr(PADDR),
    .pwdata(PWDATA),
    .prdata(PRDATA),
    .pready(PREADY),
    .pslverr(PSLVERR),
    .cfg(cfg),
    .stat(stat)
  );

  // Strict priority: lowest queue only when all above are idle
  always_comb begin
    QUEUE_GRANT = 4'h0;
    if (QUEUE_BUSY[3]) begin
      QUEUE_GRANT = 4'h8;
    end else if (QUEUE_BUSY[2]) begin
      QUEUE_GRANT = 4'h4;
    end else if (QUEUE_BUSY[1]) begin
      QUEUE_GRANT = 4'h2;
    end else if (QUEUE_BUSY[0]) begin
      QUEUE_GRANT = 4'h1; // RL15
    end
  end

  // Admission, allocation and buffer accounting
  always_comb begin
    port_used_nxt = port_used_r;
    class_used_nxt = class_used_r;
    shared_used_nxt = shared_used_r;
    mc_count_nxt = mc_count_r;
    drop_count_nxt = drop_count_r;
    dec_valid_nxt = ADM_VALID;
    dec_nxt = dec_r;
    // Releases are applied first so a same-cycle admit counts on top of them; admission checks use the registered counts
    if (REL_VALID) begin
      case (REL.region)
        BAFC_RG_CLASS: begin
          // Section 3 does not exist; such a release is ignored
          if (REL.section != 2'h3) begin
            class_used_nxt[REL.section] = cnt_dec(class_used_r[REL.section]);
          end
        end
        BAFC_RG_SHARED: shared_used_nxt = cnt_dec(shared_used_r);
        BAFC_RG_PORT: port_used_nxt[REL.src] = cnt_dec(port_used_r[REL.src]);
        default: shared_used_nxt = shared_used_nxt;
      endcase
      if (REL.mcast) begin
        mc_count_nxt = cnt_dec(mc_count_r);
      end
    end
    fc = fc_mask[ADM_REQ.src];
    q = bafc_queue_e'(cfg.prio_map[{ADM_REQ.prio, 1'b0} +: 2]); // RL7
    if (fc && cfg.force_be) begin
      q = BAFC_Q_LOWEST; // RL14
    end
    sec = sec_of(ADM_REQ.prio);
    class_ok = (ADM_REQ.prio >= `BAFC_CLASS_MIN) && (class_used_r[sec] < cfg.class_res[sec]); // RL16
    shared_ok = shared_used_r < cfg.shared_size;
    port_ok = port_used_r[ADM_REQ.src] < cfg.port_res;
    no_room = !class_ok && !shared_ok && !port_ok;
    res_left = port_ok ? cfg.port_res - port_used_r[ADM_REQ.src] : 12'h000;
    scaled = 15'(lfsr_r * `BAFC_PCT_SCALE);
    chance = scaled[14:8] < cfg.drop_pct;
    drop = no_room;
    if (!fc && q == BAFC_Q_LOWEST) begin // RL4
      if (!port_ok && !shared_ok) begin
        drop = 1'b1; // RL1
      end
      if (ADM_REQ.congest && !shared_ok && chance) begin
        drop = 1'b1; // RL2
      end
      if (ADM_REQ.congest && res_left < cfg.low_thr) begin
        drop = 1'b1; // RL3
      end
    end
    if (q != BAFC_Q_LOWEST && ADM_REQ.wred_drop) begin
      drop = 1'b1; // RL6
    end
    if (ADM_VALID) begin // RL18
      dec_nxt.drop = drop;
      dec_nxt.queue = q;
      dec_nxt.ds = ds_of(q); // RL13
      dec_nxt.src = ADM_REQ.src;
      dec_nxt.section = class_ok ? sec : 2'h0;
      if (drop) begin
        dec_nxt.region = BAFC_RG_NONE;
        if (drop_count_r != 16'hFFFF) begin
          drop_count_nxt = drop_count_r + 16'h0001;
        end
      end else if (class_ok) begin
        dec_nxt.region = BAFC_RG_CLASS; // RL17
        class_used_nxt[sec] = cnt_inc(class_used_nxt[sec]);
      end else if (shared_ok) begin
        dec_nxt.region = BAFC_RG_SHARED; // RL17
        shared_used_nxt = cnt_inc(shared_used_nxt);
      end else begin
        dec_nxt.region = BAFC_RG_PORT; // RL17
        port_used_nxt[ADM_REQ.src] = cnt_inc(port_used_nxt[ADM_REQ.src]);
      end
      if (!drop && ADM_REQ.mcast) begin
        mc_count_nxt = cnt_inc(mc_count_nxt);
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      port_used_r <= '{default: '0};
      class_used_r <= '{default: '0};
      shared_used_r <= '0;
      mc_count_r <= '0;
      drop_count_r <= '0;
      dec_valid_r <= 1'b0;
      dec_r <= '0;
    end else begin
      port_used_r <= port_used_nxt;
      class_used_r <= class_used_nxt;
      shared_used_r <= shared_used_nxt;
      mc_count_r <= mc_count_nxt;
      drop_count_r <= drop_count_nxt;
      dec_valid_r <= dec_valid_nxt;
      dec_r <= dec_nxt;
    end
  end

  assign DEC_VALID = dec_valid_r;
  assign DEC = dec_r;

  // Free-running drop dice; these taps give the full 255-state sequence
  always_comb begin
    lfsr_nxt = {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      lfsr_r <= `BAFC_LFSR_SEED;
    end else begin
      lfsr_r <= lfsr_nxt;
    end
  end

  // Flow-control capable ports, shared by admission and hold-off
  assign fc_mask = cfg.fc_cap & {`BAFC_NUM_PORTS{cfg.fc_en}};

  // Per-port unicast hold-off with hysteresis; a threshold above one keeps
  // a lone frame from ever pausing its source
  genvar p;
  generate
    for (p = 0; p < `BAFC_NUM_PORTS; p++) begin : g_uc
      always_comb begin
        uc_xoff_nxt[p] = uc_xoff_r[p];
        if (!fc_mask[p]) begin
          uc_xoff_nxt[p] = 1'b0;
        end else if (cfg.xoff_thr != 12'h000 && port_used_r[p] >= cfg.xoff_thr) begin
          uc_xoff_nxt[p] = 1'b1; // RL8 RL10
        end else if (port_used_r[p] == 12'h000) begin
          uc_xoff_nxt[p] = 1'b0; // RL9
        end
      end
    end
  endgenerate

  always_comb begin
    mc_xoff_nxt = mc_xoff_r;
    if (mc_count_r > cfg.mc_thr) begin
      mc_xoff_nxt = 1'b1; // RL11
    end else if (mc_count_r < cfg.mc_thr) begin
      mc_xoff_nxt = 1'b0; // RL12
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      uc_xoff_r <= '0;
      mc_xoff_r <= 1'b0;
    end else begin
      uc_xoff_r <= uc_xoff_nxt;
      mc_xoff_r <= mc_xoff_nxt;
    end
  end

  // Multicast hold-off hits every flow-control port at once
  assign PAUSE_STATE = (uc_xoff_r | {`BAFC_NUM_PORTS{mc_xoff_r}}) & fc_mask; // RL5

  bafc_pause u_pause (
    .clk(CLK),
    .reset(RESET),
    .state(PAUSE_STATE),
    .pause_time(cfg.pause_time),
    .frm_valid(PAUSE_VALID),
    .frm_ready(PAUSE_READY),
    .frm(PAUSE_FRM)
  );

  // Live values for the read-only status registers
  assign stat.pause_state = PAUSE_STATE;
  assign stat.mc_xoff = mc_xoff_r;
  assign stat.shared_used = shared_used_r;
  assign stat.mc_count = mc_count_r;
  assign stat.drop_count = drop_count_r;
endmodule

// [tb/bafc_top_properties.sv]
`timescale 1ns/1ps
module bafc_props import bafc_pkg::*; (
  // System
  input wire logic CLK,
  input wire logic RESET,
  // Admission
  input wire logic ADM_VALID,
  input wire bafc_adm_req_s ADM_REQ,
  input wire logic DEC_VALID,
  input wire bafc_adm_dec_s DEC,
  // Pause
  input wire logic PAUSE_VALID,
  input wire logic PAUSE_READY,
  input wire bafc_pause_s PAUSE_FRM,
  // Queues
  input wire logic [3:0] QUEUE_BUSY,
  input wire logic [3:0] QUEUE_GRANT
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  property p_dec_lat;
    ADM_VALID |=> DEC_VALID;
  endproperty
  a_dec_lat: assert property (p_dec_lat) else $error("decision missing");
  property p_dec_only;
    !ADM_VALID |=> !DEC_VALID;
  endproperty
  a_dec_only: assert property (p_dec_only) else $error("spurious decision");
  property p_dec_src;
    ADM_VALID |=> DEC.src == $past(ADM_REQ.src);
  endproperty
  a_dec_src: assert property (p_dec_src) else $error("decision source wrong");
  property p_drop_none;
    DEC_VALID && DEC.drop |-> DEC.region == BAFC_RG_NONE;
  endproperty
  a_drop_none: assert property (p_drop_none) else $error("dropped frame placed");
  property p_top;
    QUEUE_BUSY[3] |-> QUEUE_GRANT == 4'h8;
  endproperty
  a_top: assert property (p_top) else $error("top queue not first");
  property p_be;
    QUEUE_GRANT[0] |-> QUEUE_BUSY[3:1] == 3'h0;
  endproperty
  a_be: assert property (p_be) else $error("lowest queue served early");
  property p_one;
    QUEUE_BUSY != 4'h0 |-> $onehot(QUEUE_GRANT) && (QUEUE_GRANT & QUEUE_BUSY) != 4'h0;
  endproperty
  a_one: assert property (p_one) else $error("grant not one busy queue");
  property p_hold;
    PAUSE_VALID && !PAUSE_READY |=> PAUSE_VALID && $stable(PAUSE_FRM);
  endproperty
  a_hold: assert property (p_hold) else $error("pause frame dropped");
  property p_gap;
    PAUSE_VALID && PAUSE_READY |=> !PAUSE_VALID;
  endproperty
  a_gap: assert property (p_gap) else $error("no idle after pause frame");
endmodule
bind bafc_top bafc_props bafc_props_i (.CLK, .RESET, .ADM_VALID, .ADM_REQ, .DEC_VALID, .DEC,
  .PAUSE_VALID, .PAUSE_READY, .PAUSE_FRM, .QUEUE_BUSY, .QUEUE_GRANT);

// [tb/bafc_link_partner.sv]
`timescale 1ns/1ps
module bafc_link_partner import bafc_pkg::*; (
  // System
  input wire logic clk,
  input wire logic reset,
  // Pause frames
  input wire logic valid,
  input wire bafc_pause_s frm,
  output logic ready,
  // Partner state
  input wire logic [3:0] dly,
  output bafc_pmask_t hold,
  output logic [15:0] last_time
);
  logic [3:0] cnt_r, cnt_nxt;
  logic ready_nxt;
  bafc_pmask_t hold_nxt;
  logic [15:0] time_nxt;
  always_comb begin
    cnt_nxt = (valid && !ready) ? cnt_r + 4'h1 : 4'h0;
    ready_nxt = valid && !ready && cnt_r >= dly;
    hold_nxt = hold;
    time_nxt = last_time;
    if (valid && ready) begin
      // Nonzero time holds new frames off until a zero-time frame
      hold_nxt[frm.port] = frm.time_q != 16'h0;
      time_nxt = frm.time_q;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_r <= 4'h0;
      ready <= 1'b0;
      hold <= '0;
      last_time <= 16'h0;
    end else begin
      cnt_r <= cnt_nxt;
      ready <= ready_nxt;
      hold <= hold_nxt;
      last_time <= time_nxt;
    end
  end
endmodule

// [tb/bafc_top_tb.sv]
`timescale 1ns/1ps
`include "bafc_map.svh"
module bafc_top_tb import bafc_pkg::*; ;
  logic CLK, RESET, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA, q;
  logic ADM_VALID, DEC_VALID, REL_VALID, PAUSE_VALID, PAUSE_READY, e;
  bafc_adm_req_s ADM_REQ;
  bafc_adm_dec_s DEC;
  bafc_rel_s REL;
  bafc_pmask_t PAUSE_STATE, hold;
  bafc_pause_s PAUSE_FRM;
  logic [3:0] QUEUE_BUSY, QUEUE_GRANT, dly;
  logic [15:0] ltime;
  int error_cnt, n_compared, n_drop;
  localparam bafc_region_e rc = BAFC_RG_CLASS, rs = BAFC_RG_SHARED, rp = BAFC_RG_PORT, rn = BAFC_RG_NONE;
  localparam logic [31:0] rv [16] = '{32'h0, `BAFC_RST_PORT_RES, `BAFC_RST_XOFF_THR, `BAFC_RST_SHARED,
    `BAFC_RST_CLASS, `BAFC_RST_CLASS, `BAFC_RST_CLASS, `BAFC_RST_LOW_THR, `BAFC_RST_DROP_PCT,
    `BAFC_RST_MC_THR, `BAFC_RST_PRIO_MAP, `BAFC_RST_PAUSE_TIME, 32'h0, 32'h0, 32'h0, 32'h0};

  bafc_top bafc_top_i (.CLK, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
    .PSLVERR, .ADM_VALID, .ADM_REQ, .DEC_VALID, .DEC, .REL_VALID, .REL, .PAUSE_STATE, .PAUSE_VALID,
    .PAUSE_READY, .PAUSE_FRM, .QUEUE_BUSY, .QUEUE_GRANT);
  bafc_link_partner bafc_link_partner_i (.clk(CLK), .reset(RESET), .valid(PAUSE_VALID), .frm(PAUSE_FRM),
    .ready(PAUSE_READY), .dly, .hold, .last_time(ltime));

  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    $display("compared=%0d errors=%0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    // Answer looked at mid-cycle, where it stands for the coming edge
    @(negedge CLK);
    while (PREADY !== 1'b1) begin
      @(posedge CLK);
      @(negedge CLK);
    end
    q = PRDATA;
    e = PSLVERR;
    @(posedge CLK);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
  endtask

  // Queue code 4 and up skips the queue check, region none skips placement
  task automatic adm(input logic [3:0] s, input logic [2:0] p, input logic m, input logic c,
                     input logic w, input logic dr, input bafc_region_e rg, input logic [2:0] eq);
    ADM_VALID <= 1'b1;
    ADM_REQ <= '{s, p, m, c, w};
    @(posedge CLK);
    ADM_VALID <= 1'b0;
    #1;
    chk(DEC_VALID, 1);
    chk(DEC.drop, dr);
    n_drop += dr;
    if (rg != rn) chk(DEC.region, rg);
    if (!eq[2]) chk({DEC.queue, DEC.ds}, {eq[1:0], eq[1:0]});
    @(posedge CLK);
  endtask

  task automatic rel(input logic [3:0] s, input bafc_region_e r, input logic m);
    REL_VALID <= 1'b1;
    REL <= '{s, r, 2'h0, m};
    @(posedge CLK);
    REL_VALID <= 1'b0;
  endtask

  initial begin
    #200000;
    error_cnt++;
    summarize();
  end

  initial begin
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA, ADM_VALID, ADM_REQ, REL_VALID, REL} = '0;
    QUEUE_BUSY = 4'h0;
    dly = 4'h0;
    RESET = 1'b1;
    repeat (10) @(posedge CLK);
    RESET <= 1'b0;
    for (int i = 0; i < 16; i++) rd(8'(i * 4), rv[i]);
    apb(1'b1, 8'h40, 32'h1);
    chk(q, 32'h0);
    chk(32'(e), 32'h1);
    apb(1'b1, `BAFC_OFF_DROP_COUNT, 32'h5);
    rd(`BAFC_OFF_DROP_COUNT, 32'h0);
    apb(1'b1, `BAFC_OFF_SHARED, 32'h2);
    apb(1'b1, `BAFC_OFF_PORT_RES, 32'h2);
    apb(1'b1, `BAFC_OFF_XOFF_THR, 32'h2);
    apb(1'b1, `BAFC_OFF_LOW_THR, 32'h0);
    apb(1'b1, `BAFC_OFF_DROP_PCT, 32'h0);
    apb(1'b1, `BAFC_OFF_MC_THR, 32'h1);
    apb(1'b1, `BAFC_OFF_CTRL, 32'h0001_0004);
    rd(`BAFC_OFF_CTRL, 32'h0001_0004);
    for (int p = 0; p < 8; p++) adm(4'h3, 3'(p), 0, 0, 0, 0, p < 2 ? rs : rc, {1'b0, 2'(p / 2)});
    for (int i = 0; i < 3; i++) adm(4'h1, 3'h0, 0, 0, 0, i == 2, i == 2 ? rn : rp, 3'h4);
    adm(4'h4, 3'h0, 0, 1, 0, 0, rp, 3'h4);
    apb(1'b1, `BAFC_OFF_DROP_PCT, 32'h64);
    adm(4'h4, 3'h0, 0, 1, 0, 1, rn, 3'h4);
    apb(1'b1, `BAFC_OFF_DROP_PCT, 32'h0);
    apb(1'b1, `BAFC_OFF_LOW_THR, 32'h2);
    adm(4'h5, 3'h0, 0, 1, 0, 0, rp, 3'h4);
    adm(4'h5, 3'h0, 0, 1, 0, 1, rn, 3'h4);
    apb(1'b1, `BAFC_OFF_DROP_PCT, 32'h64);
    adm(4'h2, 3'h0, 0, 1, 0, 0, rp, 3'h4);
    repeat (5) @(posedge CLK);
    chk(PAUSE_STATE[2], 0);
    adm(4'h2, 3'h0, 0, 1, 0, 0, rp, 3'h4);
    repeat (10) @(posedge CLK);
    chk({PAUSE_STATE[2], hold[2]}, 2'h3);
    chk(ltime, 16'hFFFF);
    dly <= 4'h4;
    rel(4'h2, rp, 0);
    repeat (10) @(posedge CLK);
    chk(PAUSE_STATE[2], 1);
    rel(4'h2, rp, 0);
    repeat (15) @(posedge CLK);
    chk({PAUSE_STATE[2], hold[2], ltime}, 18'h0);
    adm(4'h2, 3'h6, 0, 0, 1, 1, rn, 3'h4);
    adm(4'h3, 3'h2, 0, 0, 1, 1, rn, 3'h4);
    apb(1'b1, `BAFC_OFF_CTRL, 32'h0003_0004);
    adm(4'h2, 3'h7, 0, 0, 0, 0, rn, 3'h0);
    adm(4'h3, 3'h7, 0, 0, 0, 0, rc, 3'h3);
    adm(4'h3, 3'h2, 1, 0, 0, 0, rc, 3'h4);
    adm(4'h3, 3'h2, 1, 0, 0, 0, rc, 3'h4);
    rd(`BAFC_OFF_MC_COUNT, 32'h2);
    rd(`BAFC_OFF_STATUS, 32'h0001_0004);
    rel(4'h3, rc, 1);
    rd(`BAFC_OFF_STATUS, 32'h0001_0004);
    rel(4'h3, rc, 1);
    repeat (2) @(posedge CLK);
    rd(`BAFC_OFF_STATUS, 32'h0);
    rd(`BAFC_OFF_DROP_COUNT, 32'(n_drop));
    for (int b = 0; b < 16; b++) begin
      QUEUE_BUSY <= 4'(b);
      @(posedge CLK);
      #1;
      chk(QUEUE_GRANT, b >= 8 ? 8 : b >= 4 ? 4 : b >= 2 ? 2 : b);
    end
    summarize();
  end
endmodule
